// File: src/dual_port_timestamp_capture.v
// Decided for this implementation: the AHB-Lite register port.
`include "dual_port_timestamp_capture_defs.vh"

module dual_port_timestamp_capture (
    input wire clk,
    input wire arst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire port0_line_start,
    input wire port0_frame_start,
    input wire port1_line_start,
    input wire port1_frame_start,
    output reg irq
);

    localparam [6:0] TICK0 = `TICK_RES0_CYCLES;
    localparam [6:0] TICK1 = `TICK_RES1_CYCLES;
    localparam [6:0] TICK2 = `TICK_RES2_CYCLES;
    localparam [6:0] TICK3 = `TICK_RES3_CYCLES;
    localparam [1:0] ST_COUNT = 2'h1;
    localparam [1:0] ST_ARMED = 2'h2;

    // reset release synchroniser
    reg rst_meta_ff;
    reg rst_n_ff;

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // bus slave state
    reg wr_pend_ff;
    reg rd_pend_ff;
    reg [7:0] addr_idx_ff;

    // software registers
    reg [7:0] config_ff;
    reg [7:0] control_ff;
    reg [7:0] line_upper_ff;
    reg [7:0] line_lower_ff;
    reg [2:0] evt_status_ff;
    reg [2:0] evt_enable_ff;

    // capture state
    reg [6:0] tick_cnt_ff;
    reg [15:0] ts_cnt_ff;
    reg [1:0] valid_ff;
    reg ready_ff;
    reg hold_prev_ff;

    wire [15:0] capture_line_value;
    wire capture_event_select;
    wire free_running_select;
    wire [1:0] tick_resolution;
    wire hold_captures;
    wire [1:0] port_capture_on;
    wire [1:0] line_start;
    wire [1:0] frame_start;
    wire [1:0] cap_evt;
    wire [31:0] stamp_bus;
    wire addr_phase;
    wire wr_do;
    wire hold_write;
    wire hold_release;
    wire [6:0] tick_last;
    wire tick;
    wire [1:0] nxt_valid;
    wire ready_set;
    wire nxt_ready;
    wire [2:0] evt_raw;
    wire [2:0] evt_clr;
    wire [2:0] nxt_evt_status;
    reg [7:0] rd_mux;

    assign capture_line_value = {line_upper_ff, line_lower_ff};
    assign capture_event_select = config_ff[`CFG_EVENT_SEL_BIT];
    assign free_running_select = config_ff[`CFG_FREE_RUN_BIT];
    assign tick_resolution = config_ff[`CFG_RES_MSB:`CFG_RES_LSB];
    assign hold_captures = control_ff[`CTL_HOLD_BIT];
    assign port_capture_on = {control_ff[`CTL_ON1_BIT], control_ff[`CTL_ON0_BIT]};
    assign line_start = {port1_line_start, port0_line_start};
    assign frame_start = {port1_frame_start, port0_frame_start};

    assign addr_phase = hsel && htrans[1] && hready;
    assign wr_do = wr_pend_ff;
    assign hold_write = wr_do && (addr_idx_ff == `IDX_CAPTURE_CONTROL) && hwdata[`CTL_HOLD_BIT];
    assign hold_release = hold_prev_ff && !hold_captures;

    // timestamp counter tick divider
    assign tick_last = (tick_resolution == 2'h0) ? TICK0 - 7'h01 :
                       (tick_resolution == 2'h1) ? TICK1 - 7'h01 :
                       (tick_resolution == 2'h2) ? TICK2 - 7'h01 :
                       TICK3 - 7'h01;
    assign tick = (tick_cnt_ff >= tick_last);

    always @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            tick_cnt_ff <= 7'h00;
            ts_cnt_ff <= `RST_STAMP;
        end
        else
        begin
            if (tick)
            begin
                tick_cnt_ff <= 7'h00;
                ts_cnt_ff <= ts_cnt_ff + 16'h0001;
            end
            else
            begin
                tick_cnt_ff <= tick_cnt_ff + 7'h01;
            end
        end
    end

    // per-port line counting and capture
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1)
        begin : g_port
            reg [15:0] line_cnt_ff;
            reg [1:0] state_ff;
            reg [15:0] stamp_ff;
            wire [15:0] line_next;
            wire line_hit;
            wire sel_evt;

            assign line_next = line_cnt_ff + 16'h0001;
            assign line_hit = line_start[p] && !frame_start[p] && (line_next == capture_line_value);
            assign sel_evt = !capture_event_select ? line_hit :
                             !free_running_select ? frame_start[p] :
                             (state_ff == ST_ARMED) && frame_start[p];
            assign cap_evt[p] = sel_evt && port_capture_on[p] && !hold_captures;
            assign stamp_bus[16*p+15:16*p] = stamp_ff;

            always @(posedge clk or negedge rst_n_ff)
            begin
                if (!rst_n_ff)
                begin
                    line_cnt_ff <= `RST_STAMP;
                    state_ff <= ST_COUNT;
                    stamp_ff <= `RST_STAMP;
                end
                else
                begin
                    if (frame_start[p])
                    begin
                        line_cnt_ff <= `RST_STAMP;
                    end
                    else if (line_start[p] && (line_cnt_ff != 16'hffff))
                    begin
                        line_cnt_ff <= line_next;
                    end
                    case (state_ff)
                        ST_COUNT:
                        begin
                            if (line_hit && capture_event_select && free_running_select)
                            begin
                                state_ff <= ST_ARMED;
                            end
                        end
                        ST_ARMED:
                        begin
                            if (frame_start[p] || !capture_event_select || !free_running_select)
                            begin
                                state_ff <= ST_COUNT;
                            end
                        end
                        default:
                        begin
                            state_ff <= ST_COUNT;
                        end
                    endcase
                    if (cap_evt[p])
                    begin
                        stamp_ff <= ts_cnt_ff;
                    end
                end
            end
        end
    endgenerate

    // valid and ready flags, set wins over clear
    assign nxt_valid = cap_evt | (hold_release ? 2'h0 : valid_ff);
    assign ready_set = (|cap_evt) && (|port_capture_on) &&
                       ((nxt_valid & port_capture_on) == port_capture_on);
    assign nxt_ready = ready_set | (ready_ff && !hold_write);

    // interrupt events
    assign evt_raw = {ready_set && !ready_ff, cap_evt};
    assign evt_clr = (wr_do && (addr_idx_ff == `IDX_EVENT_CLEAR)) ? hwdata[2:0] : 3'h0;
    assign nxt_evt_status = evt_raw | (evt_status_ff & ~evt_clr);

    always @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            valid_ff <= 2'h0;
            ready_ff <= 1'b0;
            hold_prev_ff <= 1'b0;
            evt_status_ff <= 3'h0;
            irq <= 1'b0;
        end
        else
        begin
            valid_ff <= nxt_valid;
            ready_ff <= nxt_ready;
            hold_prev_ff <= hold_captures;
            evt_status_ff <= nxt_evt_status;
            irq <= |(nxt_evt_status & evt_enable_ff);
        end
    end

    // register writes in the data phase
    always @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            config_ff <= `RST_BYTE;
            control_ff <= `RST_BYTE;
            line_upper_ff <= `RST_BYTE;
            line_lower_ff <= `RST_BYTE;
            evt_enable_ff <= 3'h0;
        end
        else if (wr_do)
        begin
            case (addr_idx_ff)
                `IDX_CAPTURE_CONFIG:
                begin
                    config_ff <= hwdata[7:0] & 8'h33;
                end
                `IDX_CAPTURE_CONTROL:
                begin
                    control_ff <= hwdata[7:0] & 8'h13;
                end
                `IDX_CAPTURE_LINE_UPPER:
                begin
                    line_upper_ff <= hwdata[7:0];
                end
                `IDX_CAPTURE_LINE_LOWER:
                begin
                    line_lower_ff <= hwdata[7:0];
                end
                `IDX_EVENT_ENABLE:
                begin
                    evt_enable_ff <= hwdata[2:0];
                end
                default:
                begin
                    line_lower_ff <= line_lower_ff;
                end
            endcase
        end
    end

    // read multiplexer
    always @*
    begin
        rd_mux = `RST_BYTE;
        case (addr_idx_ff)
            `IDX_CAPTURE_CONFIG:
            begin
                rd_mux = config_ff;
            end
            `IDX_CAPTURE_CONTROL:
            begin
                rd_mux = control_ff;
            end
            `IDX_CAPTURE_LINE_UPPER:
            begin
                rd_mux = line_upper_ff;
            end
            `IDX_CAPTURE_LINE_LOWER:
            begin
                rd_mux = line_lower_ff;
            end
            `IDX_STAMP_STATUS:
            begin
                rd_mux = {3'h0, ready_ff, 2'h0, valid_ff};
            end
            `IDX_PORT0_STAMP_UPPER:
            begin
                rd_mux = stamp_bus[15:8];
            end
            `IDX_PORT0_STAMP_LOWER:
            begin
                rd_mux = stamp_bus[7:0];
            end
            `IDX_PORT1_STAMP_UPPER:
            begin
                rd_mux = stamp_bus[31:24];
            end
            `IDX_PORT1_STAMP_LOWER:
            begin
                rd_mux = stamp_bus[23:16];
            end
            `IDX_EVENT_STATUS:
            begin
                rd_mux = {5'h00, evt_status_ff};
            end
            `IDX_EVENT_ENABLE:
            begin
                rd_mux = {5'h00, evt_enable_ff};
            end
            default:
            begin
                rd_mux = `RST_BYTE;
            end
        endcase
    end

    // ahb-lite slave: writes zero wait, reads one wait state
    always @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            addr_idx_ff <= `RST_BYTE;
            hrdata <= `RST_WORD;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hresp <= 1'b0;
            if (rd_pend_ff)
            begin
                hrdata <= {24'h00_0000, rd_mux};
                hreadyout <= 1'b1;
                rd_pend_ff <= 1'b0;
                wr_pend_ff <= 1'b0;
            end
            else if (addr_phase)
            begin
                addr_idx_ff <= haddr[9:2];
                wr_pend_ff <= hwrite;
                rd_pend_ff <= !hwrite;
                hreadyout <= hwrite;
            end
            else
            begin
                wr_pend_ff <= 1'b0;
                hreadyout <= 1'b1;
            end
        end
    end

endmodule // dual_port_timestamp_capture

// File: src/dual_port_timestamp_capture_defs.vh
`ifndef DUAL_PORT_TIMESTAMP_CAPTURE_DEFS_VH
`define DUAL_PORT_TIMESTAMP_CAPTURE_DEFS_VH

// register indices, byte address is four times the index
`define IDX_CAPTURE_CONFIG 8'h25
`define IDX_CAPTURE_CONTROL 8'h26
`define IDX_CAPTURE_LINE_UPPER 8'h27
`define IDX_CAPTURE_LINE_LOWER 8'h28
`define IDX_STAMP_STATUS 8'h29
`define IDX_PORT0_STAMP_UPPER 8'h2a
`define IDX_PORT0_STAMP_LOWER 8'h2b
`define IDX_PORT1_STAMP_UPPER 8'h2c
`define IDX_PORT1_STAMP_LOWER 8'h2d
`define IDX_EVENT_STATUS 8'h40
`define IDX_EVENT_ENABLE 8'h41
`define IDX_EVENT_CLEAR 8'h42

// capture_config fields
`define CFG_EVENT_SEL_BIT 0
`define CFG_FREE_RUN_BIT 1
`define CFG_RES_LSB 4
`define CFG_RES_MSB 5

// capture_control fields
`define CTL_ON0_BIT 0
`define CTL_ON1_BIT 1
`define CTL_HOLD_BIT 4

// stamp_status fields
`define STS_VALID0_BIT 0
`define STS_VALID1_BIT 1
`define STS_READY_BIT 4

// event bits
`define EVT_CAPTURE0_BIT 0
`define EVT_CAPTURE1_BIT 1
`define EVT_READY_BIT 2

// reset values
`define RST_BYTE 8'h00
`define RST_STAMP 16'h0000
`define RST_WORD 32'h0000_0000

// timing
`define CLK_PERIOD_NS 8
`define TICK_RES0_NS 40
`define TICK_RES1_NS 80
`define TICK_RES2_NS 160
`define TICK_RES3_NS 1000
`define TICK_RES0_CYCLES 7'h05
`define TICK_RES1_CYCLES 7'h0a
`define TICK_RES2_CYCLES 7'h14
`define TICK_RES3_CYCLES 7'h7d

`endif

// File: sim/dptc_checker_properties.sv
module dptc_checker (
    input wire clk,
    input wire arst_n,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire port0_line_start,
    input wire port0_frame_start,
    input wire port1_line_start,
    input wire port1_frame_start,
    input wire irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_dp_ff;
    logic rd_dp_ff;
    wire mk = port0_line_start | port0_frame_start | port1_line_start | port1_frame_start;
    // data phase markers of taken transfers
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_dp_ff <= 1'h0;
            rd_dp_ff <= 1'h0;
        end
        else
        begin
            wr_dp_ff <= hsel & htrans[1] & hwrite & hready;
            rd_dp_ff <= hsel & htrans[1] & ~hwrite & hready;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence rd_req;
        hsel && htrans[1] && !hwrite && hready;
    endsequence
    sequence wr_req;
        hsel && htrans[1] && hwrite && hready;
    endsequence
    sequence rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    chk_read_one_wait: assert property (rd_req |=> rd_wait)
        else $error("read wait state wrong");
    chk_write_no_wait: assert property (wr_req |=> hreadyout)
        else $error("write stalled");
    chk_wait_only_read: assert property ($fell(hreadyout) |-> rd_dp_ff)
        else $error("wait state without read");
    chk_resp_okay: assert property (hresp == 1'h0)
        else $error("response not okay");
    chk_byte_regs: assert property (hreadyout |-> hrdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    chk_data_holds: assert property (!rd_dp_ff |=> $stable(hrdata))
        else $error("read data moved");
    chk_irq_rise_cause: assert property ($rose(irq) |-> $past(mk) || $past(wr_dp_ff, 2))
        else $error("irq rose without cause");
    chk_irq_fall_cause: assert property ($fell(irq) |-> $past(wr_dp_ff) || $past(wr_dp_ff, 2))
        else $error("irq fell without write");
endmodule // dptc_checker

// File: sim/marker_source.sv
module marker_source (
    input wire logic clk,
    output logic ls0,
    output logic fs0,
    output logic ls1,
    output logic fs1
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {fs1, ls1, fs0, ls0} = 4'h0;
    // one-cycle markers, bits {fs1, ls1, fs0, ls0}
    task automatic pulse(input logic [3:0] m, input int gap);
        begin
            @(posedge clk);
            {fs1, ls1, fs0, ls0} <= m;
            @(posedge clk);
            {fs1, ls1, fs0, ls0} <= 4'h0;
            repeat (gap) @(posedge clk);
        end
    endtask
endmodule // marker_source

// File: sim/dual_port_timestamp_capture_tb.sv
`include "dual_port_timestamp_capture_defs.vh"
module dual_port_timestamp_capture_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0000_0000;
    wire [31:0] hrdata;
    wire hreadyout, hresp, irq, ls0, fs0, ls1, fs1;
    int err_total = 0;
    int num_checks = 0;
    logic [31:0] rd_val, s0, s1, t0;
    int divs[4] = '{5, 10, 20, 125};
    always #4 clk = ~clk;
    dual_port_timestamp_capture dual_port_timestamp_capture_i (.clk(clk), .arst_n(arst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port0_line_start(ls0),
        .port0_frame_start(fs0), .port1_line_start(ls1), .port1_frame_start(fs1), .irq(irq));
    marker_source marker_source_i (.clk(clk), .ls0(ls0), .fs0(fs0), .ls1(ls1), .fs1(fs1));
    task automatic give_verdict;
        begin
            $display("checks %0d errors %0d", num_checks, err_total);
            if (err_total == 0 && num_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        begin
            num_checks++;
            if (got !== exp)
            begin
                err_total++;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // one single word transfer, entered right after a rising edge
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] d);
        begin
            hsel <= 1'h1;
            haddr <= {22'h00_0000, idx, 2'h0};
            htrans <= 2'h2;
            hwrite <= wr;
            @(posedge clk);
            while (hreadyout !== 1'h1) @(posedge clk);
            htrans <= 2'h0;
            hsel <= 1'h0;
            hwdata <= d;
            @(posedge clk);
            while (hreadyout !== 1'h1) @(posedge clk);
            rd_val = hrdata;
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        bus(idx, 1'h1, d);
    endtask
    task automatic chk(input logic [7:0] idx, input logic [31:0] exp);
        begin
            bus(idx, 1'h0, 32'h0000_0000);
            cmp(rd_val, exp);
        end
    endtask
    task automatic get(input logic [7:0] hi, output logic [31:0] v);
        begin
            bus(hi, 1'h0, 32'h0000_0000);
            v = rd_val << 8;
            bus(hi + 8'h01, 1'h0, 32'h0000_0000);
            v = v | rd_val;
        end
    endtask
    task automatic irq_is(input logic v);
        begin
            repeat (2) @(posedge clk);
            cmp({31'h0000_0000, irq}, {31'h0000_0000, v});
        end
    endtask
    task automatic line(input logic [1:0] m);
        marker_source_i.pulse({1'h0, m[1], 1'h0, m[0]}, 1);
    endtask
    task automatic frm(input logic [1:0] m, input int n);
        begin
            marker_source_i.pulse({m[1], 1'h0, m[0], 1'h0}, 1);
            repeat (n) line(m);
        end
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        arst_n <= 1'h1;
        repeat (3) @(posedge clk);
        for (int i = 39; i <= 45; i++)
            chk(i[7:0], 32'h0000_0000);
        chk(8'h30, 32'h0000_0000);
        wr(`IDX_CAPTURE_LINE_UPPER, 32'h0000_00a5);
        wr(`IDX_CAPTURE_LINE_LOWER, 32'h0000_005a);
        chk(`IDX_CAPTURE_LINE_UPPER, 32'h0000_00a5);
        chk(`IDX_CAPTURE_LINE_LOWER, 32'h0000_005a);
        wr(`IDX_STAMP_STATUS, 32'h0000_00ff);
        wr(`IDX_PORT0_STAMP_UPPER, 32'h0000_00ff);
        chk(`IDX_STAMP_STATUS, 32'h0000_0000);
        chk(`IDX_PORT0_STAMP_UPPER, 32'h0000_0000);
        wr(`IDX_CAPTURE_LINE_UPPER, 32'h0000_0000);
        wr(`IDX_CAPTURE_LINE_LOWER, 32'h0000_0003);
        wr(`IDX_EVENT_ENABLE, 32'h0000_0007);
        wr(`IDX_CAPTURE_CONTROL, 32'h0000_0003);
        frm(2'h3, 2);
        chk(`IDX_STAMP_STATUS, 32'h0000_0000);
        line(2'h3);
        chk(`IDX_STAMP_STATUS, 32'h0000_0013);
        irq_is(1'h1);
        wr(`IDX_CAPTURE_CONTROL, 32'h0000_0013);
        chk(`IDX_STAMP_STATUS, 32'h0000_0003);
        get(`IDX_PORT0_STAMP_UPPER, s0);
        get(`IDX_PORT1_STAMP_UPPER, s1);
        cmp(s1, s0);
        frm(2'h3, 3);
        get(`IDX_PORT0_STAMP_UPPER, t0);
        cmp(t0, s0);
        chk(`IDX_EVENT_STATUS, 32'h0000_0007);
        wr(`IDX_EVENT_ENABLE, 32'h0000_0000);
        irq_is(1'h0);
        wr(`IDX_EVENT_ENABLE, 32'h0000_0007);
        irq_is(1'h1);
        wr(`IDX_EVENT_CLEAR, 32'h0000_0007);
        irq_is(1'h0);
        chk(`IDX_EVENT_STATUS, 32'h0000_0000);
        wr(`IDX_CAPTURE_CONTROL, 32'h0000_0001);
        chk(`IDX_STAMP_STATUS, 32'h0000_0000);
        frm(2'h3, 3);
        chk(`IDX_STAMP_STATUS, 32'h0000_0011);
        get(`IDX_PORT1_STAMP_UPPER, t0);
        cmp(t0, s1);
        wr(`IDX_CAPTURE_LINE_LOWER, 32'h0000_0005);
        wr(`IDX_CAPTURE_CONFIG, 32'h0000_0003);
        wr(`IDX_CAPTURE_CONTROL, 32'h0000_0011);
        wr(`IDX_CAPTURE_CONTROL, 32'h0000_0001);
        frm(2'h1, 4);
        frm(2'h1, 0);
        chk(`IDX_STAMP_STATUS, 32'h0000_0000);
        repeat (5) line(2'h1);
        frm(2'h1, 0);
        chk(`IDX_STAMP_STATUS, 32'h0000_0011);
        for (int r = 0; r < 4; r++)
        begin
            wr(`IDX_CAPTURE_CONFIG, 32'h0000_0001 | (r << 4));
            wr(`IDX_CAPTURE_CONTROL, 32'h0000_0013);
            wr(`IDX_CAPTURE_CONTROL, 32'h0000_0003);
            marker_source_i.pulse(4'h2, 10 * divs[r] - 2);
            marker_source_i.pulse(4'h8, 0);
            wr(`IDX_CAPTURE_CONTROL, 32'h0000_0013);
            get(`IDX_PORT0_STAMP_UPPER, s0);
            get(`IDX_PORT1_STAMP_UPPER, s1);
            cmp((s1 - s0) & 32'h0000_ffff, 32'h0000_000a);
        end
        give_verdict;
    end
    initial
    begin
        repeat (30000) @(posedge clk);
        err_total++;
        give_verdict;
    end
endmodule // dual_port_timestamp_capture_tb
bind dual_port_timestamp_capture dptc_checker dptc_checker_i (.clk, .arst_n, .hsel, .htrans, .hwrite,
    .hready, .hrdata, .hreadyout, .hresp, .port0_line_start, .port0_frame_start, .port1_line_start,
    .port1_frame_start, .irq);
